/* src/gas_mode_defines.svh */
// Constants for the gas sensor mode controller and reading scheduler.
// Assumes a 125 MHz system clock and a host-side command decoder.
`ifndef GAS_MODE_DEFINES_SVH
`define GAS_MODE_DEFINES_SVH
`define CLK_HZ          125000000
`define READ_RATE_HZ    2
`define BAUD_RATE       9600
`define READ_PERIOD_CYC (`CLK_HZ / `READ_RATE_HZ)
`define BIT_CYC         (`CLK_HZ / `BAUD_RATE)
`define MEAS_BUSY_MS    10
`define MEAS_BUSY_CYC   ((`CLK_HZ / 1000) * `MEAS_BUSY_MS)
`define MODE_SLEEP      2'h0
`define MODE_STREAM     2'h1
`define MODE_POLL       2'h2
`define FILTER_RESET    8'h10
`define DATA_W          16
`endif

/* src/gas_mode_pkg.sv */
// Types for the gas sensor mode controller.
// Assumes the defines header is included by the users.
package gas_mode_pkg;
	typedef enum logic [1:0] {
		sleep_type_st,
		stream_type_st,
		poll_type_st
	} mode_type;
	typedef enum logic [2:0] {
		cmd_none,
		cmd_mode,
		cmd_read_filt,
		cmd_read_raw,
		cmd_filter,
		cmd_zero
	} cmd_type;
endpackage : gas_mode_pkg

/* src/gas_sensor_mode_control.sv */
// Mode control, measurement pacing and reply scheduling.
// Assumes a decoded command strobe from a host receiver on clk_i and a
// measurement engine that runs whenever meas_start_o pulses.
`include "gas_mode_defines.svh"
module gas_sensor_mode_control #(
	parameter int unsigned READ_PERIOD = `READ_PERIOD_CYC,
	parameter int unsigned BUSY_CYC    = `MEAS_BUSY_CYC
) (
	input  wire logic                  clk_i,
	input  wire logic                  reset_n_i,
	input  wire logic                  cmd_valid_i,
	input  wire gas_mode_pkg::cmd_type cmd_i,
	input  wire logic [7:0]            cmd_arg_i,
	input  wire logic                  nv_mode_i,
	input  wire logic [`DATA_W-1:0]    filt_data_i,
	input  wire logic [`DATA_W-1:0]    raw_data_i,
	input  wire logic                  meas_done_i,
	output logic                       meas_start_o,
	output logic                       nv_write_o,
	output logic                       nv_mode_o,
	output logic                       reply_valid_o,
	output logic                       reply_reject_o,
	output logic [`DATA_W-1:0]         reply_data_o,
	output logic [7:0]                 filter_o,
	output logic [1:0]                 mode_o,
	output logic                       busy_o
);
	logic                rst_s1_r, rst_n_r;
	logic                started_r;
	gas_mode_pkg::mode_type mode_r;
	logic [28:0]         tick_cnt_r;
	logic [20:0]         busy_cnt_r;
	logic [`DATA_W-1:0]  filt_r, raw_r;
	logic                pend_r;
	gas_mode_pkg::cmd_type pend_cmd_r;
	logic [7:0]          pend_arg_r;
	logic [7:0]          filter_r;
	logic                nvw_r, nvm_r;
	logic                rv_r, rj_r;
	logic [`DATA_W-1:0]  rd_r;

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	wire tick_w      = (tick_cnt_r == 29'(READ_PERIOD - 1));
	wire sleeping_w  = (mode_r == gas_mode_pkg::sleep_type_st);
	wire busy_w      = (busy_cnt_r != 21'h0);
	wire start_w     = tick_w && !sleeping_w && started_r;
	wire cmd_in_w    = cmd_valid_i || pend_r;
	wire gas_mode_pkg::cmd_type cur_cmd_w = pend_r ? pend_cmd_r : cmd_i;
	wire [7:0]       cur_arg_w = pend_r ? pend_arg_r : cmd_arg_i;
	wire exec_w      = cmd_in_w && !(mode_r == gas_mode_pkg::stream_type_st && busy_w);
	wire reject_w    = sleeping_w && (cur_cmd_w == gas_mode_pkg::cmd_read_filt ||
	                   cur_cmd_w == gas_mode_pkg::cmd_read_raw ||
	                   cur_cmd_w == gas_mode_pkg::cmd_zero);
	wire mode_cmd_w  = exec_w && cur_cmd_w == gas_mode_pkg::cmd_mode && cur_arg_w <= 8'h02;
	wire stream_w    = meas_done_i && mode_r == gas_mode_pkg::stream_type_st;

	always_ff @(posedge clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			started_r  <= 1'b0;
			mode_r     <= gas_mode_pkg::stream_type_st;
			tick_cnt_r <= 29'h0;
			busy_cnt_r <= 21'h0;
			filt_r     <= 16'h0;
			raw_r      <= 16'h0;
			pend_r     <= 1'b0;
			pend_cmd_r <= gas_mode_pkg::cmd_none;
			pend_arg_r <= 8'h0;
			filter_r   <= `FILTER_RESET;
			nvw_r      <= 1'b0;
			nvm_r      <= 1'b0;
			rv_r       <= 1'b0;
			rj_r       <= 1'b0;
			rd_r       <= 16'h0;
		end
		else
		begin
			nvw_r <= 1'b0;
			rv_r  <= 1'b0;
			rj_r  <= 1'b0;
			if (!started_r)
			begin
				started_r <= 1'b1;
				mode_r    <= nv_mode_i ? gas_mode_pkg::poll_type_st : gas_mode_pkg::stream_type_st;
			end
			tick_cnt_r <= tick_w ? 29'h0 : tick_cnt_r + 29'h1;
			if (start_w)
				busy_cnt_r <= 21'(BUSY_CYC);
			else if (busy_w)
				busy_cnt_r <= busy_cnt_r - 21'h1;
			if (meas_done_i)
			begin
				filt_r <= filt_data_i;
				raw_r  <= raw_data_i;
			end
			if (cmd_valid_i && !exec_w && !pend_r)
			begin
				pend_r     <= 1'b1;
				pend_cmd_r <= cmd_i;
				pend_arg_r <= cmd_arg_i;
			end
			if (exec_w)
			begin
				pend_r <= 1'b0;
				rv_r   <= 1'b1;
				rj_r   <= reject_w;
				rd_r   <= (cur_cmd_w == gas_mode_pkg::cmd_read_raw) ? raw_r : filt_r;
				if (cur_cmd_w == gas_mode_pkg::cmd_filter && !reject_w)
					filter_r <= cur_arg_w;
			end
			if (mode_cmd_w)
			begin
				mode_r <= gas_mode_pkg::mode_type'(cur_arg_w[1:0]);
				if (cur_arg_w != 8'h00)
				begin
					nvw_r <= 1'b1;
					nvm_r <= (cur_arg_w == 8'h02);
				end
			end
			else if (stream_w && !exec_w)
			begin
				rv_r <= 1'b1;
				rd_r <= filt_data_i;
			end
		end
	end

	assign meas_start_o   = start_w;
	assign nv_write_o     = nvw_r;
	assign nv_mode_o      = nvm_r;
	assign reply_valid_o  = rv_r;
	assign reply_reject_o = rj_r;
	assign reply_data_o   = rd_r;
	assign filter_o       = filter_r;
	assign mode_o         = mode_r;
	assign busy_o         = busy_w;

	property p_reject;
		@(posedge clk_i) disable iff (!rst_n_r)
		(exec_w && reject_w) |=> (reply_valid_o && reply_reject_o);
	endproperty
	a_reject: assert property (p_reject) else $error("sleep read not rejected");
	property p_sleep_nomeas;
		@(posedge clk_i) disable iff (!rst_n_r)
		sleeping_w |-> !meas_start_o;
	endproperty
	a_sleep_nomeas: assert property (p_sleep_nomeas) else $error("measuring in sleep");
	property p_poll_quiet;
		@(posedge clk_i) disable iff (!rst_n_r)
		(mode_r == gas_mode_pkg::poll_type_st && !cmd_in_w && meas_done_i) |=> !reply_valid_o;
	endproperty
	a_poll_quiet: assert property (p_poll_quiet) else $error("unsolicited in poll");
	property p_defer;
		@(posedge clk_i) disable iff (!rst_n_r)
		pend_r |-> busy_w || exec_w;
	endproperty
	a_defer: assert property (p_defer) else $error("deferred too long");
	property p_nv;
		@(posedge clk_i) disable iff (!rst_n_r)
		(mode_cmd_w && cur_arg_w == 8'h02) |=> (nv_write_o && nv_mode_o);
	endproperty
	a_nv: assert property (p_nv) else $error("poll not stored");
	property p_stream;
		@(posedge clk_i) disable iff (!rst_n_r)
		(stream_w && !exec_w && !mode_cmd_w) |=> (reply_valid_o && reply_data_o == $past(filt_data_i));
	endproperty
	a_stream: assert property (p_stream) else $error("stream reading missing");
endmodule : gas_sensor_mode_control

/* testbench/meas_model.sv */
// Measurement engine and nonvolatile mode store facing the controller.
// Assumes start pulses come no closer than the measurement time.
module meas_model #(
	parameter int unsigned DLY = 6
) (
	input  wire logic clk_i,
	input  wire logic start_i,
	input  wire logic nv_write_i,
	input  wire logic nv_mode_i,
	output logic      done_o,
	output logic      nv_mode_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	initial done_o = 1'b0;
	initial nv_mode_o = 1'b0;
	always @(posedge clk_i)
	begin
		if (nv_write_i)
			nv_mode_o <= nv_mode_i;
		done_o <= (cnt == 1);
		if (start_i)
			cnt <= DLY;
		else if (cnt != 0)
			cnt <= cnt - 1;
	end
endmodule : meas_model

/* testbench/tb_top.sv */
// Self-checking bench for the mode controller.
// Assumes shortened counts; inputs change at falling edges.
`include "gas_mode_defines.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned PER = 100;
	logic clk_i = 1'b0, reset_n_i = 1'b0, cmd_valid_i = 1'b0;
	gas_mode_pkg::cmd_type cmd_i = gas_mode_pkg::cmd_none;
	logic [7:0] cmd_arg_i = 8'h00, filter_o;
	logic [`DATA_W-1:0] filt_data_i = 16'h1234, raw_data_i = 16'h4321, reply_data_o, last;
	logic nv_mode_i, meas_done_i, meas_start_o, nv_write_o, nv_mode_o;
	logic reply_valid_o, reply_reject_o, busy_o;
	logic [1:0] mode_o;
	logic [31:0] rng = 32'd80942;
	int n_mismatch = 0, samples_checked = 0, n_rep, n_st;
	always #4 clk_i = ~clk_i;
	gas_sensor_mode_control #(.READ_PERIOD(PER), .BUSY_CYC(10)) uut (.clk_i, .reset_n_i,
		.cmd_valid_i, .cmd_i, .cmd_arg_i, .nv_mode_i, .filt_data_i, .raw_data_i,
		.meas_done_i, .meas_start_o, .nv_write_o, .nv_mode_o, .reply_valid_o,
		.reply_reject_o, .reply_data_o, .filter_o, .mode_o, .busy_o);
	meas_model far (.clk_i, .start_i(meas_start_o), .nv_write_i(nv_write_o),
		.nv_mode_i(nv_mode_o), .done_o(meas_done_i), .nv_mode_o(nv_mode_i));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	// Out-of-range mode numbers leave the mode alone
	function automatic logic [1:0] exp_mode(input logic [7:0] a, input logic [1:0] cur);
		return (a <= 8'h02) ? a[1:0] : cur;
	endfunction : exp_mode
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cmd(input gas_mode_pkg::cmd_type c, input logic [7:0] a);
		int i;
		@(negedge clk_i);
		cmd_valid_i = 1'b1;
		cmd_i = c;
		cmd_arg_i = a;
		@(negedge clk_i);
		cmd_valid_i = 1'b0;
		for (i = 0; i < 40 && reply_valid_o !== 1'b1; i++)
			@(negedge clk_i);
		chk(reply_valid_o, 1'b1);
	endtask : cmd
	// Sampled at falling edges, where the start pulse is settled
	task automatic watch(input int cyc);
		n_rep = 0;
		n_st = 0;
		repeat (cyc)
		begin
			@(negedge clk_i);
			if (reply_valid_o === 1'b1)
				last = reply_data_o;
			n_rep += (reply_valid_o === 1'b1);
			n_st += (meas_start_o === 1'b1);
		end
	endtask : watch
	task automatic rst;
		reset_n_i = 1'b0;
		repeat (3) @(negedge clk_i);
		reset_n_i = 1'b1;
		repeat (6) @(negedge clk_i);
	endtask : rst
	task automatic test_done;
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done
	initial
	begin
		#20000;
		n_mismatch++;
		test_done();
	end
	initial
	begin
		rst();
		chk(mode_o, 2'h1);
		chk(filter_o, `FILTER_RESET);
		watch(PER * 5 / 2);
		chk(n_rep / 2, 1);
		chk(last, 16'h1234);
		rng = xs(rng);
		filt_data_i = rng[15:0];
		raw_data_i = rng[31:16];
		cmd(gas_mode_pkg::cmd_mode, 8'h02);
		chk(mode_o, 2'h2);
		// The store takes the write pulse one edge after the reply
		@(negedge clk_i);
		chk(nv_mode_i, 1'b1);
		cmd(gas_mode_pkg::cmd_mode, 8'h03);
		chk(mode_o, exp_mode(8'h03, 2'h2));
		watch(PER + 20);
		chk(n_rep, 0);
		chk(n_st > 0, 1'b1);
		cmd(gas_mode_pkg::cmd_read_filt, 8'h00);
		chk(reply_data_o, filt_data_i);
		cmd(gas_mode_pkg::cmd_read_raw, 8'h00);
		chk(reply_data_o, raw_data_i);
		cmd(gas_mode_pkg::cmd_filter, rng[7:0]);
		chk(filter_o, rng[7:0]);
		cmd(gas_mode_pkg::cmd_mode, 8'h00);
		chk(mode_o, 2'h0);
		chk(nv_mode_i, 1'b1);
		cmd(gas_mode_pkg::cmd_read_filt, 8'h00);
		chk(reply_reject_o, 1'b1);
		cmd(gas_mode_pkg::cmd_zero, 8'h00);
		chk(reply_reject_o, 1'b1);
		watch(PER + 20);
		chk(n_st, 0);
		rst();
		chk(mode_o, 2'h2);
		cmd(gas_mode_pkg::cmd_mode, 8'h01);
		@(negedge clk_i);
		chk(nv_mode_i, 1'b0);
		rst();
		chk(mode_o, 2'h1);
		test_done();
	end
endmodule : tb_top
